// ===== pkg/osg_map.svh
// Purpose: constants for the operation status group
// Assumes: one 100 MHz clock, synchronous active-high reset
// Notes: included by the package and by the design modules
//
// Behaviour
// [R1] Status byte bit 7 is 1 while any event bit ANDed with its mask bit is 1.
// [R2] With the mask at 256 only the scan-complete flag can raise the summary bit.
// [R3] A read of the enable mask returns its current value.
// [R4] Event bit 8 is set when a scan cycle finishes and holds until an event read.
// [R5] A read of the event register returns its contents and then clears every bit.
// [R6] An event register read returns 256 when the scan-complete flag is set and 0 otherwise.
// [R7] An aborted scan never sets the scan-complete flag.
// [R8] The condition register never shows the scan-complete bit as 1.
// [R9] A preset clears every mask bit and leaves the event register untouched.
// [R10] Completion in an event read cycle returns the old value and leaves the flag set.
`ifndef OSG_MAP_SVH
`define OSG_MAP_SVH

`define OSG_WIDTH 16
`define OSG_SCAN_DONE_BIT 8
`define OSG_SUMMARY_POS 7
`define OSG_SCAN_ONLY_MASK 16'h0100
`define OSG_EVT_RESET 16'h0000
`define OSG_MASK_RESET 16'h0000
`define OSG_COND_VALUE 16'h0000

`endif

// ===== pkg/osg_pkg.sv
// Purpose: shared types of the operation status group
// Assumes: osg_map.svh gives the widths
// Notes: none
`include "osg_map.svh"

package osg_pkg;
  typedef logic [`OSG_WIDTH-1:0] osg_word_t;

  typedef enum logic {
    OSG_IDLE,
    OSG_SCANNING
  } osg_scan_e;
endpackage

// ===== pkg/osg_evt_if.sv
// Purpose: carries set, clear and value of the event latch
// Assumes: one clock domain, owned by the modules on both sides
// Notes: no clocking block
interface osg_evt_if;
  import osg_pkg::*;
  osg_word_t set_vec;
  logic clear;
  osg_word_t value;

  modport owner (input set_vec, input clear, output value);
  modport user (output set_vec, output clear, input value);
endinterface

// ===== hw/osg_event_latch.sv
// Purpose: sticky event bits with clear on read
// Assumes: set and clear come from logic on the same clock
// Notes: a set in the clear cycle survives the clear
`include "osg_map.svh"

module osg_event_latch
  import osg_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_sys_rst,
  osg_evt_if.owner evt
);

  // ****************************************
  // latch
  // ****************************************
  // set is ORed after the clear so a completion is never lost
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      evt.value <= `OSG_EVT_RESET;
    end else begin
      evt.value <= (evt.value & ~{`OSG_WIDTH{evt.clear}}) | evt.set_vec; // [R5] [R10]
    end
  end

  // ****************************************
  // checks
  // ****************************************
  property p_set_sticks;
    @(posedge i_clk) disable iff (i_sys_rst)
    (evt.set_vec != `OSG_EVT_RESET) |=> ((evt.value & $past(evt.set_vec)) == $past(evt.set_vec));
  endproperty
  a_set_sticks: assert property (p_set_sticks) // [R10]
    else $error("set event bit was not latched");

  property p_hold_without_clear;
    @(posedge i_clk) disable iff (i_sys_rst)
    !evt.clear |=> ((evt.value & $past(evt.value)) == $past(evt.value));
  endproperty
  a_hold_without_clear: assert property (p_hold_without_clear) // [R4]
    else $error("event bit dropped without a read");

endmodule

// ===== hw/osg_top.sv
// Purpose: operation status group: event latch, enable mask, summary bit
// Assumes: scan and query strobes come from logic on the same clock
// Notes: all outputs are registered; summary lags the latch by one cycle
`include "osg_map.svh"

module osg_top
  import osg_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_scan_start,
  input wire logic i_scan_done,
  input wire logic i_scan_abort,
  input wire logic i_evt_rd,
  input wire logic i_mask_wr,
  input wire logic [`OSG_WIDTH-1:0] i_mask_wdata,
  input wire logic i_preset,
  output logic [`OSG_WIDTH-1:0] o_evt_rdata,
  output logic o_evt_rd_valid,
  output logic [`OSG_WIDTH-1:0] o_mask_rdata,
  output logic [`OSG_WIDTH-1:0] o_oper_cond,
  output logic o_operation_summary_bit,
  output logic o_scan_busy
);

  // ****************************************
  // declarations
  // ****************************************
  osg_scan_e scan_state;
  osg_word_t mask;
  logic scan_done_ok;
  logic any_enabled;

  osg_evt_if evt ();

  // ****************************************
  // scan tracking
  // ****************************************
  // a completion only counts inside a scan; abort in the same cycle wins
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      scan_state <= OSG_IDLE;
    end else begin
      unique case (scan_state)
        OSG_IDLE: begin
          if (i_scan_start && !i_scan_abort) begin
            scan_state <= OSG_SCANNING;
          end
        end
        OSG_SCANNING: begin
          if (i_scan_abort || i_scan_done) begin
            scan_state <= OSG_IDLE; // [R7]
          end
        end
      endcase
    end
  end

  assign scan_done_ok = (scan_state == OSG_SCANNING) && i_scan_done && !i_scan_abort; // [R7]

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_scan_busy <= 1'b0;
    end else begin
      o_scan_busy <= (scan_state == OSG_SCANNING);
    end
  end

  // ****************************************
  // event latch
  // ****************************************
  // only the scan-complete bit is ever set, so reads give 256 or 0
  assign evt.set_vec = scan_done_ok ? `OSG_SCAN_ONLY_MASK : `OSG_EVT_RESET; // [R4] [R6]
  assign evt.clear = i_evt_rd; // [R5]

  osg_event_latch osg_event_latch_inst (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .evt(evt.owner)
  );

  // the value read is the one before the clear and before a same-cycle set
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_evt_rdata <= `OSG_EVT_RESET;
      o_evt_rd_valid <= 1'b0;
    end else begin
      o_evt_rd_valid <= i_evt_rd;
      if (i_evt_rd) begin
        o_evt_rdata <= evt.value; // [R5] [R6] [R10]
      end
    end
  end

  // ****************************************
  // enable mask
  // ****************************************
  // preset beats a write in the same cycle
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      mask <= `OSG_MASK_RESET;
    end else if (i_preset) begin
      mask <= `OSG_MASK_RESET; // [R9]
    end else if (i_mask_wr) begin
      mask <= i_mask_wdata;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_mask_rdata <= `OSG_MASK_RESET;
    end else begin
      o_mask_rdata <= mask; // [R3]
    end
  end

  // ****************************************
  // summary and condition
  // ****************************************
  assign any_enabled = |(evt.value & mask); // [R1] [R2]

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_operation_summary_bit <= 1'b0;
    end else begin
      o_operation_summary_bit <= any_enabled; // [R1]
    end
  end

  // completion is momentary, so the condition view never holds it
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_oper_cond <= `OSG_COND_VALUE;
    end else begin
      o_oper_cond <= `OSG_COND_VALUE; // [R8]
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_sys_rst);

  sequence s_scan_end;
    scan_done_ok ##1 evt.value[`OSG_SCAN_DONE_BIT];
  endsequence

  sequence s_summary_up;
    ##1 o_operation_summary_bit;
  endsequence

  property p_summary_and;
    o_operation_summary_bit == $past(any_enabled);
  endproperty
  a_summary_and: assert property (p_summary_and) // [R1]
    else $error("summary bit does not follow masked events");

  property p_scan_only_mask;
    (mask == `OSG_SCAN_ONLY_MASK) && !i_preset && !i_mask_wr && !i_evt_rd
      ##0 s_scan_end |-> s_summary_up;
  endproperty
  a_scan_only_mask: assert property (p_scan_only_mask) // [R2]
    else $error("scan complete did not raise summary");

  property p_scan_only_quiet;
    (mask == `OSG_SCAN_ONLY_MASK) && !evt.value[`OSG_SCAN_DONE_BIT] |=>
      !o_operation_summary_bit;
  endproperty
  a_scan_only_quiet: assert property (p_scan_only_quiet) // [R2]
    else $error("summary raised without scan complete");

  property p_mask_read;
    ##1 o_mask_rdata == $past(mask);
  endproperty
  a_mask_read: assert property (p_mask_read) // [R3]
    else $error("mask read differs from mask");

  property p_flag_set;
    scan_done_ok |-> s_scan_end;
  endproperty
  a_flag_set: assert property (p_flag_set) // [R4]
    else $error("scan completion not latched");

  property p_flag_hold;
    evt.value[`OSG_SCAN_DONE_BIT] && !i_evt_rd |=> evt.value[`OSG_SCAN_DONE_BIT];
  endproperty
  a_flag_hold: assert property (p_flag_hold) // [R4]
    else $error("scan flag cleared without a read");

  property p_read_clears;
    i_evt_rd && !scan_done_ok |=>
      (evt.value == `OSG_EVT_RESET) && o_evt_rd_valid && (o_evt_rdata == $past(evt.value));
  endproperty
  a_read_clears: assert property (p_read_clears) // [R5]
    else $error("event read did not return then clear");

  property p_read_values;
    o_evt_rd_valid |-> (o_evt_rdata == `OSG_SCAN_ONLY_MASK) || (o_evt_rdata == `OSG_EVT_RESET);
  endproperty
  a_read_values: assert property (p_read_values) // [R6]
    else $error("event read returned an unused bit");

  property p_abort_no_set;
    i_scan_abort && !evt.value[`OSG_SCAN_DONE_BIT] |=> !evt.value[`OSG_SCAN_DONE_BIT];
  endproperty
  a_abort_no_set: assert property (p_abort_no_set) // [R7]
    else $error("abort set the scan flag");

  property p_cond_clear;
    !o_oper_cond[`OSG_SCAN_DONE_BIT];
  endproperty
  a_cond_clear: assert property (p_cond_clear) // [R8]
    else $error("condition shows scan complete");

  property p_preset;
    i_preset && !i_evt_rd && !scan_done_ok |=>
      (mask == `OSG_MASK_RESET) && (evt.value == $past(evt.value));
  endproperty
  a_preset: assert property (p_preset) // [R9]
    else $error("preset failed or touched events");

  property p_same_cycle;
    scan_done_ok && i_evt_rd |=>
      evt.value[`OSG_SCAN_DONE_BIT] && (o_evt_rdata == $past(evt.value));
  endproperty
  a_same_cycle: assert property (p_same_cycle) // [R10]
    else $error("completion lost in read cycle");

endmodule

// ===== verification/osg_top_bench.sv
// Purpose: self-checking bench for the operation status group
// Assumes: osg_top with one clock and a synchronous active-high reset
// Notes: strobes change 1 ns after the rising edge, so no edge races
`include "osg_map.svh"

module osg_top_bench;
  timeunit 1ns;
  timeprecision 100ps;

  logic i_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic st = 1'b0;
  logic dn = 1'b0;
  logic ab = 1'b0;
  logic rd = 1'b0;
  logic mw = 1'b0;
  logic pr = 1'b0;
  osg_pkg::osg_word_t wd = 16'h0000;
  osg_pkg::osg_word_t rdata;
  osg_pkg::osg_word_t mrd;
  osg_pkg::osg_word_t cond;
  logic vld;
  logic sum;
  logic busy;
  int fail_count = 0;
  int checks = 0;

  osg_top osg_top_inst (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_scan_start(st),
    .i_scan_done(dn),
    .i_scan_abort(ab),
    .i_evt_rd(rd),
    .i_mask_wr(mw),
    .i_mask_wdata(wd),
    .i_preset(pr),
    .o_evt_rdata(rdata),
    .o_evt_rd_valid(vld),
    .o_mask_rdata(mrd),
    .o_oper_cond(cond),
    .o_operation_summary_bit(sum),
    .o_scan_busy(busy)
  );

  initial begin
    forever #5 i_clk = ~i_clk;
  end

  // ****************************************
  // tasks
  // ****************************************
  task automatic tk(input int n = 1);
    repeat (n) @(posedge i_clk);
    #1;
  endtask

  task automatic chk16(input osg_pkg::osg_word_t got, input osg_pkg::osg_word_t exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // answer lands one edge after the strobe and is looked at in that cycle;
  // a trailing edge keeps back-to-back reads from touching the strobe twice at once
  task automatic evt_read(input osg_pkg::osg_word_t exp);
    rd = 1'b1;
    tk();
    rd = 1'b0;
    chk1(vld, 1'b1);
    chk16(rdata, exp);
    tk();
  endtask

  task automatic mask_write(input osg_pkg::osg_word_t v);
    mw = 1'b1;
    wd = v;
    tk();
    mw = 1'b0;
    tk(2);
    chk16(mrd, v);
  endtask

  // done is ignored while idle, so a scan always starts first;
  // busy is registered from the state, so it shows one edge after the start edge
  task automatic scan(input logic d, input logic a);
    st = 1'b1;
    tk();
    st = 1'b0;
    dn = d;
    ab = a;
    tk();
    dn = 1'b0;
    ab = 1'b0;
    chk1(busy, 1'b1);
    tk(2);
    chk1(busy, 1'b0);
  endtask

  task automatic finish_test;
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ****************************************
  // tests
  // ****************************************
  initial begin
    tk(16);
    i_sys_rst = 1'b0;
    chk16(mrd, 16'h0000);
    evt_read(16'h0000);
    mask_write(16'h0100);
    scan(1'b1, 1'b0);
    chk1(sum, 1'b1);
    chk16(cond, 16'h0000);
    tk(5);
    chk1(sum, 1'b1);
    evt_read(16'h0100);
    evt_read(16'h0000);
    tk();
    chk1(sum, 1'b0);
    scan(1'b0, 1'b1);
    dn = 1'b1;
    tk();
    dn = 1'b0;
    tk(2);
    evt_read(16'h0000);
    scan(1'b1, 1'b1);
    evt_read(16'h0000);
    st = 1'b1;
    tk();
    st = 1'b0;
    dn = 1'b1;
    rd = 1'b1;
    tk();
    dn = 1'b0;
    rd = 1'b0;
    chk16(rdata, 16'h0000);
    tk();
    evt_read(16'h0100);
    mask_write(16'hfeff);
    scan(1'b1, 1'b0);
    chk1(sum, 1'b0);
    mask_write(16'hffff);
    chk1(sum, 1'b1);
    pr = 1'b1;
    mw = 1'b1;
    wd = 16'h0100;
    tk();
    pr = 1'b0;
    mw = 1'b0;
    tk(2);
    chk16(mrd, 16'h0000);
    chk1(sum, 1'b0);
    evt_read(16'h0100);
    finish_test;
  end

  // whole sequence needs well under 200 cycles
  initial begin
    #20us;
    fail_count++;
    finish_test;
  end
endmodule
